// file: verilog/rcoc_top.v
// Second recovered-clock output control: register slave, source select and squelch
`timescale 1ns/1ps
`include "rcoc_map.vh"

module rcoc_top (
	input  wire        aclk,
	input  wire        aresetn,
	// Register bus, AXI4-Lite
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Per-port recovered clock levels and link state
	input  wire [3:0]  serial_rclk,
	input  wire [3:0]  copper_rclk,
	input  wire [3:0]  link_up,
	input  wire [3:0]  link_stable,
	input  wire [7:0]  link_speed,
	input  wire [3:0]  gig_master,
	input  wire [3:0]  eee_mode,
	input  wire [3:0]  lp_idle_rx,
	input  wire        ext_squelch,
	// Clock output side
	output reg         recovered_clock_two_output,
	output reg         recovered_clock_two_drive,
	output reg  [2:0]  recovered_clock_two_rate
);

	// Control register and bus state
	reg  [15:0] ctrl_q;
	reg  [15:0] ctrl_d;
	reg  [7:0]  awaddr_q;
	reg         aw_full_q;
	reg  [15:0] wdata_q;
	reg  [1:0]  wstrb_q;
	reg         w_full_q;
	reg  [31:0] rd_word;
	reg         rd_hit;

	// Decoded control fields
	wire        en;
	wire [3:0]  src;
	wire [2:0]  freq;
	wire [1:0]  level;
	wire [2:0]  kind;
	wire [1:0]  port;
	wire        src_ok;
	wire        kind_ok;

	// Selected port signals
	wire        sel_clk;
	wire [1:0]  sel_speed;
	wire        squelch;
	wire        wr_go;
	wire        aw_hs;
	wire        w_hs;
	wire        ar_hs;
	reg  [3:0]  wr_state_q;
	reg  [3:0]  wr_state_d;
	reg  [2:0]  rd_state_q;
	reg  [2:0]  rd_state_d;

	// One-hot channel states; a write waits for both halves before it commits
	localparam [3:0] WR_OPEN   = 4'b0001;
	localparam [3:0] WR_COMMIT = 4'b0010;
	localparam [3:0] WR_RESP   = 4'b0100;
	localparam [3:0] WR_DRAIN  = 4'b1000;
	localparam [2:0] RD_OPEN   = 3'b001;
	localparam [2:0] RD_DATA   = 3'b010;
	localparam [2:0] RD_DRAIN  = 3'b100;

	// Picks one bit of a per-port vector
	function sel4;
		input [3:0] vec;
		input [1:0] idx;
		begin
			sel4 = vec[idx];
		end
	endfunction

	// Tells whether a byte address names one of the two words
	function addr_hit;
		input [7:0] addr;
		begin
			addr_hit = (addr == `RCOC_CTRL_ADDR) || (addr == `RCOC_STAT_ADDR);
		end
	endfunction

	// Field views of the control register
	assign en      = ctrl_q[`RCOC_EN_BIT];
	assign src     = ctrl_q[`RCOC_SRC_HI:`RCOC_SRC_LO];
	assign freq    = ctrl_q[`RCOC_FREQ_HI:`RCOC_FREQ_LO];
	assign level   = ctrl_q[`RCOC_SQL_HI:`RCOC_SQL_LO];
	assign kind    = ctrl_q[`RCOC_KIND_HI:`RCOC_KIND_LO];
	assign port    = src[1:0];

	// Reserved codes select no clock rather than alias onto a real port
	assign src_ok  = (src[3:2] == 2'h0);
	assign kind_ok = (kind == `RCOC_KIND_SERIAL) || (kind == `RCOC_KIND_COPPER);

	// Source multiplexer: port first, then the kind of recovered clock
	assign sel_clk = (kind == `RCOC_KIND_COPPER) ? sel4(copper_rclk, port)
		: sel4(serial_rclk, port);
	assign sel_speed = link_speed[{port, 1'b0} +: 2];

	// Squelch policy on the selected port's link state
	rcoc_squelch u_squelch (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.level       (level),
		.link_up     (sel4(link_up, port)),
		.link_stable (sel4(link_stable, port)),
		.speed       (sel_speed),
		.gig_master  (sel4(gig_master, port)),
		.eee_mode    (sel4(eee_mode, port)),
		.lp_idle_rx  (sel4(lp_idle_rx, port)),
		.ext_squelch (ext_squelch),
		.squelch_q   (squelch)
	);

	// Bus handshakes; each ready is a flop so the slave never answers combinationally
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs  = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wr_go = (wr_state_q == WR_COMMIT);

	// Write address and data are caught independently, in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			awaddr_q  <= 8'h00;
			w_full_q  <= 1'b0;
			wdata_q   <= 16'h0000;
			wstrb_q   <= 2'h0;
		end else begin
			if (aw_hs) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (w_hs) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata[15:0];
				wstrb_q  <= s_axi_wstrb[1:0];
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// Readies drop on their own handshake and rise again once the response is gone
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= (wr_state_d == WR_OPEN) & ~aw_full_q & ~aw_hs;
			s_axi_wready  <= (wr_state_d == WR_OPEN) & ~w_full_q & ~w_hs;
		end
	end

	// Write sequence: collect both halves, commit, answer, reopen one edge after the answer
	always @* begin
		wr_state_d = wr_state_q;
		case (wr_state_q)
			WR_OPEN: begin
				if ((aw_full_q | aw_hs) & (w_full_q | w_hs)) begin
					wr_state_d = WR_COMMIT;
				end
			end
			WR_COMMIT: begin
				wr_state_d = WR_RESP;
			end
			WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_d = WR_DRAIN;
				end
			end
			WR_DRAIN: begin
				wr_state_d = WR_OPEN;
			end
			default: begin
				wr_state_d = WR_OPEN;
			end
		endcase
	end

	// Write state register
	always @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= WR_OPEN;
		end else begin
			wr_state_q <= wr_state_d;
		end
	end

	// Byte-lane merge into the control word; reserved bits stay zero
	always @* begin
		ctrl_d = ctrl_q;
		if (wstrb_q[0]) begin
			ctrl_d[7:0] = wdata_q[7:0];
		end
		if (wstrb_q[1]) begin
			ctrl_d[15:8] = wdata_q[15:8];
		end
		ctrl_d = ctrl_d & `RCOC_CTRL_WMASK;
	end

	// Control register; the status word ignores writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= `RCOC_CTRL_RESET;
		end else if (wr_go && (awaddr_q == `RCOC_CTRL_ADDR)) begin
			ctrl_q <= ctrl_d;
		end
	end

	// Write response two edges after the later of the address and data handshakes
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RCOC_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_hit(awaddr_q) ? `RCOC_RESP_OKAY : `RCOC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux: the status word shows what the output logic is really doing
	always @* begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			`RCOC_CTRL_ADDR: begin
				rd_word[15:0] = ctrl_q & `RCOC_CTRL_WMASK;
			end
			`RCOC_STAT_ADDR: begin
				rd_word[0] = squelch;
				rd_word[1] = recovered_clock_two_drive;
				rd_word[2] = sel4(link_up, port);
				rd_word[3] = ext_squelch;
				rd_word[4] = src_ok & kind_ok;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read channel: data one edge after the address handshake, held until taken
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RCOC_RESP_OKAY;
		end else begin
			s_axi_arready <= (rd_state_d == RD_OPEN) & ~ar_hs;
			if (ar_hs) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_hit ? `RCOC_RESP_OKAY : `RCOC_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
			end
		end
	end

	// Read sequence: answer, then reopen the address one edge after the data is taken
	always @* begin
		rd_state_d = rd_state_q;
		case (rd_state_q)
			RD_OPEN: begin
				if (ar_hs) begin
					rd_state_d = RD_DATA;
				end
			end
			RD_DATA: begin
				if (s_axi_rready) begin
					rd_state_d = RD_DRAIN;
				end
			end
			RD_DRAIN: begin
				rd_state_d = RD_OPEN;
			end
			default: begin
				rd_state_d = RD_OPEN;
			end
		endcase
	end

	// Read state register
	always @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= RD_OPEN;
		end else begin
			rd_state_q <= rd_state_d;
		end
	end

	// Output stage: a squelched or disabled output is held low, never left floating
	always @(posedge aclk) begin
		if (!aresetn) begin
			recovered_clock_two_output <= 1'b0;
			recovered_clock_two_drive  <= 1'b0;
			recovered_clock_two_rate   <= `RCOC_FREQ_25M;
		end else begin
			recovered_clock_two_drive  <= en & src_ok & kind_ok & ~squelch;
			recovered_clock_two_output <= en & src_ok & kind_ok & ~squelch
				& sel_clk;
			recovered_clock_two_rate   <= freq;
		end
	end

endmodule

// file: verilog/rcoc_map.vh
// Register map, field layout and codes of the second recovered-clock control block
`ifndef RCOC_MAP_VH
`define RCOC_MAP_VH

// Byte addresses on the register bus
`define RCOC_CTRL_ADDR      8'h18
`define RCOC_STAT_ADDR      8'h1c
`define RCOC_ADDR_W         8

// Control register layout
`define RCOC_CTRL_RESET     16'h0000
`define RCOC_CTRL_WMASK     16'hff37
`define RCOC_EN_BIT         15
`define RCOC_SRC_HI         14
`define RCOC_SRC_LO         11
`define RCOC_FREQ_HI        10
`define RCOC_FREQ_LO        8
`define RCOC_SQL_HI         5
`define RCOC_SQL_LO         4
`define RCOC_KIND_HI        2
`define RCOC_KIND_LO        0

// Squelch levels
`define RCOC_SQL_AUTO       2'h0
`define RCOC_SQL_AUTO_ALL   2'h1
`define RCOC_SQL_LINK_ONLY  2'h2
`define RCOC_SQL_OFF        2'h3

// Source kinds and frequency codes
`define RCOC_KIND_SERIAL    3'h0
`define RCOC_KIND_COPPER    3'h1
`define RCOC_FREQ_25M       3'h0
`define RCOC_FREQ_125M      3'h1
`define RCOC_FREQ_31M25     3'h2
`define RCOC_NUM_PORTS      4

// Link speed codes of each port
`define RCOC_SPD_10         2'h0
`define RCOC_SPD_100        2'h1
`define RCOC_SPD_1000       2'h2

// Bus response codes
`define RCOC_RESP_OKAY      2'h0
`define RCOC_RESP_SLVERR    2'h2

`endif

// file: verilog/rcoc_squelch.v
// Squelch decision for the selected port of the second recovered-clock output
`timescale 1ns/1ps
`include "rcoc_map.vh"

module rcoc_squelch (
	input  wire       aclk,
	input  wire       aresetn,
	input  wire [1:0] level,
	input  wire       link_up,
	input  wire       link_stable,
	input  wire [1:0] speed,
	input  wire       gig_master,
	input  wire       eee_mode,
	input  wire       lp_idle_rx,
	input  wire       ext_squelch,
	output reg        squelch_q
);

	wire       spd10;
	wire       spd100;
	wire       gig_slave;
	wire       down;
	wire       eee_sq;
	reg        squelch_d;

	// Link conditions of the two automatic levels; spd10 is used by RCOC_SQL_AUTO only
	assign spd10     = (speed == `RCOC_SPD_10);
	assign spd100    = (speed == `RCOC_SPD_100);
	assign gig_slave = (speed == `RCOC_SPD_1000) & ~gig_master;
	assign down      = ~link_up | ~link_stable;
	assign eee_sq    = eee_mode & (spd100 | gig_slave);

	// The pin wins over every level, so it is tested last
	always @* begin
		case (level)
			`RCOC_SQL_AUTO: begin
				squelch_d = down | ((speed == `RCOC_SPD_1000) & gig_master) | spd10
					| eee_sq;
			end
			`RCOC_SQL_AUTO_ALL: begin
				squelch_d = down | (eee_sq & ~lp_idle_rx);
			end
			`RCOC_SQL_LINK_ONLY: begin
				squelch_d = ~link_up;
			end
			default: begin
				squelch_d = 1'b0;
			end
		endcase
		if (ext_squelch) begin
			squelch_d = 1'b1;
		end
	end

	// Registered so the output path sees a clean level
	always @(posedge aclk) begin
		if (!aresetn) begin
			squelch_q <= 1'b1;
		end else begin
			squelch_q <= squelch_d;
		end
	end

endmodule

// file: verification/rcoc_sink.sv
// Downstream timing circuit model that counts rising edges of the recovered clock
`timescale 1ns/1ps

module rcoc_sink (
	input  wire logic       aclk,
	input  wire logic       clr,
	input  wire logic       clk_in,
	output logic      [7:0] cnt
);
	logic last_q;

	// Counts every rise seen, so a squelched output must leave the count at zero
	always @(posedge aclk) begin
		last_q <= clk_in;
		if (clr)
			cnt <= 8'h00;
		else if (clk_in && !last_q)
			cnt <= cnt + 8'h01;
	end
endmodule

// file: verification/rcoc_top_properties.sv
// Concurrent checks on the ports of the recovered-clock control block
`timescale 1ns/1ps

module rcoc_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_squelch,
	input wire logic recovered_clock_two_output,
	input wire logic recovered_clock_two_drive
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_aw_to_b: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write response late");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready)) else $error("write not reopened");
	a_ar_to_r: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid ##1 s_axi_arready) else $error("read not reopened");
	a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response open");
	a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data open");
	a_pin_squelch: assert property (ext_squelch[*3]
		|-> !recovered_clock_two_output && !recovered_clock_two_drive) else $error("pin ignored");
	a_drive_gate: assert property (!recovered_clock_two_drive[*2]
		|-> !recovered_clock_two_output) else $error("output runs while not driven");
endmodule

bind rcoc_top rcoc_props u_props (.*);

// file: verification/rcoc_top_tb.sv
// Self-checking bench for the second recovered-clock control block
`timescale 1ns/1ps
`include "rcoc_map.vh"

module rcoc_top_tb;
	logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0, run, ext_squelch = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, link_speed = 8'h00, cnt;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, recovered_clock_two_rate;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hf, serial_rclk = 4'h0, copper_rclk = 4'h0, ts = 4'h0;
	logic [3:0]  tc = 4'h0, link_up = 4'h0, link_stable = 4'h0, gig_master = 4'h0;
	logic [3:0]  eee_mode = 4'h0, lp_idle_rx = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        recovered_clock_two_output, recovered_clock_two_drive;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [10:0] cases [8];
	int          num_errors = 0, comparisons = 0, cyc = 0;

	rcoc_top dut (.*);
	rcoc_sink u_sink (.aclk(aclk), .clr(clr), .clk_in(recovered_clock_two_output), .cnt(cnt));

	always #5 aclk = ~aclk;

	// Recovered clocks toggle only on the lines picked by the masks, so a wrong pick stays quiet
	always @(posedge aclk) begin
		serial_rclk <= serial_rclk ^ ts;
		copper_rclk <= copper_rclk ^ tc;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end

	task final_report;
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input logic [31:0] e, input logic [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED at %0t expected %h got %h", $time, e, g);
		end
	endtask

	// Address and data are offered together and each is released once taken
	task wr(input logic [7:0] a, input logic [15:0] d);
		logic ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready && !ad) begin
				s_axi_awvalid <= 1'b0;
				ad = 1;
			end
			if (s_axi_wready && !wd) begin
				s_axi_wvalid <= 1'b0;
				wd = 1;
			end
		end while (!(ad && wd));
		do @(posedge aclk); while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Settle after a change, then see whether any clock edge reaches the sink
	task meas;
		repeat (4) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		repeat (16) @(posedge aclk);
		run = (cnt != 8'h00);
	endtask

	initial begin
		// Port state in the top seven bits, run mask by squelch level in the low four
		cases = '{11'h288, 11'h48c, 11'h74e, 11'h60e, 11'h6ac, 11'h6be, 11'h68f, 11'h72c};
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(`RCOC_CTRL_ADDR);
		chk(32'h0, rd);
		chk(`RCOC_RESP_OKAY, resp);
		ts <= 4'hf;
		link_up <= 4'hf;
		link_stable <= 4'hf;
		meas;
		chk(1'b0, run);
		wr(`RCOC_CTRL_ADDR, 16'hffff);
		rdr(`RCOC_CTRL_ADDR);
		chk(32'hff37, rd);
		chk(3'h7, recovered_clock_two_rate);
		meas;
		chk(1'b0, run);
		wr(`RCOC_CTRL_ADDR, 16'ha030);
		meas;
		chk(1'b0, run);
		wr(`RCOC_CTRL_ADDR, 16'h8032);
		meas;
		chk(1'b0, run);
		for (int i = 0; i < 8; i++) begin
			ts <= i[0] ? 4'h0 : 4'h1 << i[2:1];
			tc <= i[0] ? 4'h1 << i[2:1] : 4'h0;
			wr(`RCOC_CTRL_ADDR, {1'b1, 2'b00, i[2:1], 3'(i % 3), 4'h3, 3'h0, i[0]});
			meas;
			chk(1'b1, run);
			chk(3'(i % 3), recovered_clock_two_rate);
		end
		ts <= 4'h1;
		tc <= 4'h0;
		foreach (cases[k]) for (int l = 0; l < 4; l++) begin
			link_up <= {4{cases[k][10]}};
			link_stable <= {4{cases[k][9]}};
			link_speed <= {4{cases[k][8:7]}};
			gig_master <= {4{cases[k][6]}};
			eee_mode <= {4{cases[k][5]}};
			lp_idle_rx <= {4{cases[k][4]}};
			wr(`RCOC_CTRL_ADDR, {8'h80, 2'b00, 2'(l), 4'h0});
			meas;
			chk(cases[k][l], run);
		end
		ext_squelch <= 1'b1;
		meas;
		chk(1'b0, run);
		rdr(`RCOC_STAT_ADDR);
		chk(32'h1d, rd);
		ext_squelch <= 1'b0;
		meas;
		chk(1'b1, run);
		rdr(`RCOC_STAT_ADDR);
		chk(32'h16, rd);
		wr(8'h40, 16'hffff);
		chk(`RCOC_RESP_SLVERR, resp);
		rdr(8'h40);
		chk(`RCOC_RESP_SLVERR, resp);
		chk(32'h0, rd);
		rdr(`RCOC_CTRL_ADDR);
		chk(32'h8030, rd);
		s_axi_wstrb <= 4'h2;
		wr(`RCOC_CTRL_ADDR, 16'h12ff);
		s_axi_wstrb <= 4'hf;
		rdr(`RCOC_CTRL_ADDR);
		chk(32'h1230, rd);
		final_report;
	end
endmodule
